/* File: operand_store.sv */
`timescale 1ns/1ps
module operand_store (
   input wire logic i_mclk,
   input wire logic i_load,
   input wire logic [7:0] i_load_data,
   input wire logic i_we,
   input wire logic [7:0] i_wdata,
   output logic [7:0] o_rdata
);
   logic [7:0] cell_q;
   // Bypass: a fresh operand is readable in the cycle it is loaded
   assign o_rdata = i_load ? i_load_data : cell_q;
   always_ff @(posedge i_mclk) begin
      if (i_load) begin
         cell_q <= i_load_data;
      end else if (i_we) begin
         cell_q <= i_wdata;
      end
   end
endmodule : operand_store

/* File: rss_adder.sv */
`timescale 1ns/1ps
module rss_adder (
   input wire logic [7:0] i_a,
   input wire logic [7:0] i_b,
   input wire logic i_cin,
   output logic [7:0] o_sum,
   output logic o_cout,
   output logic o_half,
   output logic o_ovf
);
   logic [4:0] low;
   logic [8:0] full;
   always_comb begin
      low = {1'b0, i_a[3:0]} + {1'b0, i_b[3:0]} + {4'h0, i_cin};
      full = {1'b0, i_a} + {1'b0, i_b} + {8'h00, i_cin};
      o_sum = full[7:0];
      o_cout = full[8];
      // Carry out of the low nibble
      o_half = low[4];
      // Signed overflow: like-signed inputs, differing result
      o_ovf = (i_a[7] == i_b[7]) && (full[7] != i_a[7]);
   end
endmodule : rss_adder

/* File: rss_datapath.sv */
// Overview of operation
// - Rotate left through carry to memory: carry into bit 0, bit 7 into carry.
// - Same rotate to working register; memory untouched, carry from bit 7.
// - Rotate right to memory: bit 0 into bit 7, flags unchanged.
// - Rotate right to working register only; memory and flags unchanged.
// - Rotate right through carry to memory: carry into bit 7, bit 0 into carry.
// - Same rotate to working register; carry from bit 0, memory kept.
// - Borrow subtract: working plus inverted operand plus carry, four flags updated.
// - Plain subtract: working plus inverted operand plus one, four flags updated.
// - True skip condition discards prefetched instruction: two cycles, else one.
// - Decrement memory operand, write back, skip on zero, flags unchanged.
// - Decrement into working register, memory kept, skip on zero.
// - Increment memory operand, write back, skip on zero, flags unchanged.
// - Increment into working register, memory kept, skip on zero.
// - Skip when selected operand bit is one; no flag change.
// - Byte set writes all ones to memory, no flag change.
// - Bit set forces only selected bit to one, no flag change.
`timescale 1ns/1ps
module rss_datapath (
   input wire logic i_mclk,
   input wire logic i_reset_n,
   input wire logic i_clk_en,
   input wire logic i_start,
   input wire rss_pkg::op_t i_op,
   input wire logic [7:0] i_mem_data,
   input wire logic [2:0] i_bit_sel,
   output logic [7:0] o_working,
   output logic o_carry,
   output logic o_half_borrow_flag,
   output logic o_zero,
   output logic o_signed_range_flag,
   output logic o_mem_we,
   output logic [7:0] o_mem_wdata,
   output logic o_discard,
   output logic o_busy,
   output logic o_done
);
   // ==========================================================
   // Sequencer
   typedef enum logic [1:0] {
      st_idle = 2'b01,
      st_dummy = 2'b10
   } state_t;

   state_t state_q, state_d;
   logic [7:0] working_q, working_d;
   logic [3:0] flags_q, flags_d;
   logic mem_we_q, mem_we_d;
   logic [7:0] mem_wdata_q, mem_wdata_d;
   logic discard_q, discard_d;
   logic done_q, done_d;
   logic [7:0] add_b;
   logic add_cin;
   logic [7:0] add_sum;
   logic add_cout, add_half, add_ovf;
   logic [7:0] res;
   logic skip;

   // ==========================================================
   // Helpers
   // One-hot mask shared by the bit test and the bit set
   function automatic logic [7:0] bit_mask(input logic [2:0] sel);
      bit_mask = rss_pkg::ONE << sel;
   endfunction : bit_mask

   // ==========================================================
   // Operand adder
   // Subtract as addition of the inverted operand
   always_comb begin
      add_b = ~i_mem_data;
      add_cin = (i_op == rss_pkg::borrow_minus_to_working || i_op == rss_pkg::borrow_minus_to_memory)
         ? flags_q[rss_pkg::FLAG_CARRY] : 1'b1;
   end

   rss_adder u_adder (
      .i_a(working_q),
      .i_b(add_b),
      .i_cin(add_cin),
      .o_sum(add_sum),
      .o_cout(add_cout),
      .o_half(add_half),
      .o_ovf(add_ovf)
   );

   // ==========================================================
   // Execute
   always_comb begin
      state_d = state_q;
      working_d = working_q;
      flags_d = flags_q;
      mem_we_d = 1'b0;
      mem_wdata_d = mem_wdata_q;
      discard_d = 1'b0;
      done_d = 1'b0;
      res = i_mem_data;
      skip = 1'b0;
      unique case (state_q)
         st_idle: begin
            // Any enabled edge with start takes an instruction
            if (i_start) begin
               done_d = 1'b1;
               // Result first, destination second: one path serves both variants
               unique case (i_op)
                  rss_pkg::rotate_left_with_carry, rss_pkg::rotate_left_with_carry_to_working: begin
                     res = {i_mem_data[6:0], flags_q[rss_pkg::FLAG_CARRY]};
                     flags_d[rss_pkg::FLAG_CARRY] = i_mem_data[7];
                  end
                  rss_pkg::rotate_right, rss_pkg::rotate_right_to_working: begin
                     res = {i_mem_data[0], i_mem_data[7:1]};
                  end
                  rss_pkg::rotate_right_with_carry, rss_pkg::rotate_right_with_carry_to_working: begin
                     res = {flags_q[rss_pkg::FLAG_CARRY], i_mem_data[7:1]};
                     flags_d[rss_pkg::FLAG_CARRY] = i_mem_data[0];
                  end
                  rss_pkg::borrow_minus_to_working, rss_pkg::borrow_minus_to_memory,
                  rss_pkg::minus_to_working, rss_pkg::minus_to_memory: begin
                     // Carry set means no borrow
                     res = add_sum;
                     flags_d[rss_pkg::FLAG_CARRY] = add_cout;
                     flags_d[rss_pkg::FLAG_HALF] = add_half;
                     flags_d[rss_pkg::FLAG_ZERO] = (add_sum == 8'h00);
                     flags_d[rss_pkg::FLAG_SIGNED] = add_ovf;
                  end
                  rss_pkg::decrement_skip_zero, rss_pkg::decrement_skip_zero_to_working: begin
                     // Zero flag left alone: only the skip reports the zero result
                     res = i_mem_data - rss_pkg::ONE;
                     skip = (res == 8'h00);
                  end
                  rss_pkg::increment_skip_zero, rss_pkg::increment_skip_zero_to_working: begin
                     res = i_mem_data + rss_pkg::ONE;
                     skip = (res == 8'h00);
                  end
                  rss_pkg::bit_high_skip: begin
                     skip = |(i_mem_data & bit_mask(i_bit_sel));
                  end
                  rss_pkg::byte_set: begin
                     res = rss_pkg::ALL_ONES;
                  end
                  rss_pkg::bit_set: begin
                     res = i_mem_data | bit_mask(i_bit_sel);
                  end
                  default: begin
                     // Unlisted codes only complete
                     done_d = 1'b1;
                  end
               endcase

               // Destination select
               unique case (i_op)
                  rss_pkg::rotate_left_with_carry_to_working, rss_pkg::rotate_right_to_working,
                  rss_pkg::rotate_right_with_carry_to_working, rss_pkg::borrow_minus_to_working,
                  rss_pkg::minus_to_working, rss_pkg::decrement_skip_zero_to_working,
                  rss_pkg::increment_skip_zero_to_working: begin
                     working_d = res;
                  end
                  rss_pkg::rotate_left_with_carry, rss_pkg::rotate_right, rss_pkg::rotate_right_with_carry,
                  rss_pkg::borrow_minus_to_memory, rss_pkg::minus_to_memory, rss_pkg::decrement_skip_zero,
                  rss_pkg::increment_skip_zero, rss_pkg::byte_set, rss_pkg::bit_set: begin
                     mem_we_d = 1'b1;
                     mem_wdata_d = res;
                  end
                  default: begin
                     mem_we_d = 1'b0;
                  end
               endcase
               // Skip: done is held back to the dummy cycle
               if (skip) begin
                  discard_d = 1'b1;
                  done_d = 1'b0;
                  state_d = st_dummy;
               end
            end
         end
         st_dummy: begin
            // Start is not looked at here; the fetch side re-presents it next cycle
            done_d = 1'b1;
            state_d = st_idle;
         end
         default: begin
            state_d = st_idle;
         end
      endcase
   end

   // ==========================================================
   // State registers
   // Clock enable low freezes every register, pulses included
   always_ff @(posedge i_mclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         state_q <= st_idle;
         working_q <= rss_pkg::WORKING_RESET;
         flags_q <= rss_pkg::FLAGS_RESET;
         mem_we_q <= 1'b0;
         mem_wdata_q <= 8'h00;
         discard_q <= 1'b0;
         done_q <= 1'b0;
      end else if (i_clk_en) begin
         state_q <= state_d;
         working_q <= working_d;
         flags_q <= flags_d;
         mem_we_q <= mem_we_d;
         mem_wdata_q <= mem_wdata_d;
         discard_q <= discard_d;
         done_q <= done_d;
      end
   end

   // ==========================================================
   // Outputs
   always_comb begin
      o_working = working_q;
      o_carry = flags_q[rss_pkg::FLAG_CARRY];
      o_half_borrow_flag = flags_q[rss_pkg::FLAG_HALF];
      o_zero = flags_q[rss_pkg::FLAG_ZERO];
      o_signed_range_flag = flags_q[rss_pkg::FLAG_SIGNED];
      o_mem_we = mem_we_q;
      o_mem_wdata = mem_wdata_q;
      o_discard = discard_q;
      // One-hot: the dummy state bit is the busy flop
      o_busy = state_q[1];
      o_done = done_q;
   end
endmodule : rss_datapath

/* File: rss_datapath_asserts.sv */
`timescale 1ns/1ps
module rss_datapath_checker (
   input wire logic i_mclk,
   input wire logic i_reset_n,
   input wire logic i_clk_en,
   input wire logic i_start,
   input wire rss_pkg::op_t i_op,
   input wire logic [7:0] i_mem_data,
   input wire logic [2:0] i_bit_sel,
   input wire logic [7:0] o_working,
   input wire logic o_carry,
   input wire logic o_mem_we,
   input wire logic [7:0] o_mem_wdata,
   input wire logic o_discard,
   input wire logic o_busy,
   input wire logic o_done
);
   default clocking @(posedge i_mclk); endclocking
   default disable iff (!i_reset_n);
   logic tk;
   assign tk = i_start && i_clk_en && !o_busy;
   // ==========================================================
   // Properties
   chk_left_carry_mem:
   assert property (tk && i_op == rss_pkg::rotate_left_with_carry |=> o_mem_we
      && o_mem_wdata == {$past(i_mem_data[6:0]), $past(o_carry)} && o_carry == $past(i_mem_data[7])) else $error("lc");
   chk_left_carry_work:
   assert property (tk && i_op == rss_pkg::rotate_left_with_carry_to_working |=> !o_mem_we
      && o_working == {$past(i_mem_data[6:0]), $past(o_carry)}) else $error("lcw");
   chk_right_plain_mem:
   assert property (tk && i_op == rss_pkg::rotate_right |=> o_mem_we && $stable(o_carry)
      && o_mem_wdata == {$past(i_mem_data[0]), $past(i_mem_data[7:1])}) else $error("rp");
   chk_right_carry_work:
   assert property (tk && i_op == rss_pkg::rotate_right_with_carry_to_working |=> !o_mem_we
      && o_working == {$past(o_carry), $past(i_mem_data[7:1])} && o_carry == $past(i_mem_data[0])) else $error("rcw");
   chk_skip_two_cycles:
   assert property (o_discard |-> o_busy && !o_done ##1 o_done && !o_busy) else $error("skip timing");
   chk_inc_mem_skip:
   assert property (tk && i_op == rss_pkg::increment_skip_zero |=> o_mem_we
      && o_mem_wdata == $past(i_mem_data) + 8'h01 && o_discard == ($past(i_mem_data) == 8'hff)) else $error("inc");
   chk_dec_work_skip:
   assert property (tk && i_op == rss_pkg::decrement_skip_zero_to_working |=> !o_mem_we
      && o_working == $past(i_mem_data) - 8'h01 && o_discard == ($past(i_mem_data) == 8'h01)) else $error("dec");
   chk_bit_test_skip:
   assert property (tk && i_op == rss_pkg::bit_high_skip |=> !o_mem_we
      && o_discard == $past(i_mem_data[i_bit_sel])) else $error("bit test");
   chk_byte_all_ones:
   assert property (tk && i_op == rss_pkg::byte_set |=> o_mem_we && o_mem_wdata == 8'hff && $stable(o_carry))
      else $error("byte set");
   cover property (o_discard);
   cover property (tk && i_op == rss_pkg::minus_to_memory);
   cover property (i_start && i_clk_en && o_busy);
endmodule : rss_datapath_checker
bind rss_datapath rss_datapath_checker rss_datapath_checker_i (.i_mclk(i_mclk), .i_reset_n(i_reset_n),
   .i_clk_en(i_clk_en), .i_start(i_start), .i_op(i_op), .i_mem_data(i_mem_data), .i_bit_sel(i_bit_sel),
   .o_working(o_working), .o_carry(o_carry), .o_mem_we(o_mem_we), .o_mem_wdata(o_mem_wdata),
   .o_discard(o_discard), .o_busy(o_busy), .o_done(o_done));

/* File: rss_datapath_test.sv */
`timescale 1ns/1ps
module rss_datapath_test;
   logic i_mclk = 0, i_reset_n = 0, i_start = 0, load = 0, we, disc, we_s = 0, disc_s = 0, c;
   logic o_carry, o_half, o_zero, o_signed, o_mem_we, o_discard, o_busy, o_done;
   rss_pkg::op_t i_op = rss_pkg::op_none;
   logic [7:0] m = 8'h00, w = 8'h00, rdata, o_working, o_mem_wdata, wd, wd_s, r;
   logic [2:0] i_bit_sel = 3'h0;
   logic [3:0] fl = 4'h0;
   logic [8:0] s;
   logic [4:0] h;
   logic [21:0] notes[$], note;
   int mismatches = 0, n_compared = 0;
   rss_datapath rss_datapath_i (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_clk_en(1'b1), .i_start(i_start),
      .i_op(i_op), .i_mem_data(rdata), .i_bit_sel(i_bit_sel), .o_working(o_working), .o_carry(o_carry),
      .o_half_borrow_flag(o_half), .o_zero(o_zero), .o_signed_range_flag(o_signed), .o_mem_we(o_mem_we),
      .o_mem_wdata(o_mem_wdata), .o_discard(o_discard), .o_busy(o_busy), .o_done(o_done));
   operand_store operand_store_i (.i_mclk(i_mclk), .i_load(load), .i_load_data(m), .i_we(o_mem_we),
      .i_wdata(o_mem_wdata), .o_rdata(rdata));
   initial forever #5 i_mclk = ~i_mclk;
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic give_verdict();
      $display("Compared %0d, mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : give_verdict
   // ==========================================================
   // Reference model
   task automatic model();
      r = w;
      disc = 0;
      we = i_op inside {rss_pkg::rotate_left_with_carry, rss_pkg::rotate_right, rss_pkg::rotate_right_with_carry,
         rss_pkg::borrow_minus_to_memory, rss_pkg::minus_to_memory, rss_pkg::decrement_skip_zero,
         rss_pkg::increment_skip_zero, rss_pkg::byte_set, rss_pkg::bit_set};
      case (i_op)
         rss_pkg::rotate_left_with_carry, rss_pkg::rotate_left_with_carry_to_working: begin
            r = {m[6:0], fl[0]};
            fl[0] = m[7];
         end
         rss_pkg::rotate_right, rss_pkg::rotate_right_to_working: r = {m[0], m[7:1]};
         rss_pkg::rotate_right_with_carry, rss_pkg::rotate_right_with_carry_to_working: begin
            r = {fl[0], m[7:1]};
            fl[0] = m[0];
         end
         rss_pkg::borrow_minus_to_working, rss_pkg::borrow_minus_to_memory, rss_pkg::minus_to_working,
         rss_pkg::minus_to_memory: begin
            c = (i_op inside {rss_pkg::minus_to_working, rss_pkg::minus_to_memory}) ? 1'b1 : fl[0];
            s = {1'b0, w} + {1'b0, ~m} + 9'(c);
            h = {1'b0, w[3:0]} + {1'b0, ~m[3:0]} + 5'(c);
            r = s[7:0];
            fl = {(w[7] == ~m[7]) && (r[7] != w[7]), r == 8'h00, h[4], s[8]};
         end
         rss_pkg::decrement_skip_zero, rss_pkg::decrement_skip_zero_to_working: r = m - 8'h01;
         rss_pkg::increment_skip_zero, rss_pkg::increment_skip_zero_to_working: r = m + 8'h01;
         rss_pkg::bit_high_skip: disc = m[i_bit_sel];
         rss_pkg::byte_set: r = 8'hff;
         rss_pkg::bit_set: r = m | (8'h01 << i_bit_sel);
         default: r = w;
      endcase
      if (i_op >= rss_pkg::decrement_skip_zero && i_op <= rss_pkg::increment_skip_zero_to_working) disc = (r == 8'h00);
      wd = we ? r : 8'h00;
      if (!we) w = r;
   endtask : model
   // ==========================================================
   // Driver and watchdog
   initial begin
      void'($urandom(32'h0000_c78a));
      repeat (16) @(negedge i_mclk);
      i_reset_n = 1;
      for (int k = 0; k < 400; k++) begin
         @(negedge i_mclk);
         i_op = rss_pkg::op_t'($urandom_range(17, 0));
         m = k[0] ? 8'($urandom) : {8{k[1]}} ^ {7'h00, k[2]};
         i_bit_sel = 3'($urandom);
         i_start = 1;
         load = 1;
         model();
         notes.push_back({w, fl, we, wd, disc});
         if (disc) begin
            repeat (int'(rss_pkg::SKIP_CYCLES) - 1) @(negedge i_mclk);
            // Start during the dummy cycle must be ignored
            i_op = rss_pkg::byte_set;
         end
      end
      @(negedge i_mclk);
      i_start = 0;
      for (int k = 0; k < 8 && notes.size() > 0; k++) @(negedge i_mclk);
      if (notes.size() > 0) mismatches++;
      give_verdict();
   end
   initial begin
      repeat (20000) @(posedge i_mclk);
      mismatches++;
      give_verdict();
   end
   // ==========================================================
   // Monitor
   always @(negedge i_mclk) begin
      if (o_mem_we === 1'b1) begin
         we_s = 1;
         wd_s = o_mem_wdata;
      end
      if (o_discard === 1'b1) disc_s = 1;
      if (o_done === 1'b1) begin
         if (notes.size() == 0) check(16'h0001, 16'h0000);
         else begin
            note = notes.pop_front();
            check({o_working, o_signed, o_zero, o_half, o_carry}, note[21:10]);
            check(we_s, note[9]);
            if (note[9]) check(wd_s, note[8:1]);
            check(disc_s, note[0]);
         end
         we_s = 0;
         disc_s = 0;
      end
   end
endmodule : rss_datapath_test

/* File: rss_pkg.sv */
package rss_pkg;
   // ==========================================================
   // Operation codes
   typedef enum logic [4:0] {
      op_none = 5'h00,
      rotate_left_with_carry = 5'h01,
      rotate_left_with_carry_to_working = 5'h02,
      rotate_right = 5'h03,
      rotate_right_to_working = 5'h04,
      rotate_right_with_carry = 5'h05,
      rotate_right_with_carry_to_working = 5'h06,
      borrow_minus_to_working = 5'h07,
      borrow_minus_to_memory = 5'h08,
      minus_to_working = 5'h09,
      minus_to_memory = 5'h0a,
      decrement_skip_zero = 5'h0b,
      decrement_skip_zero_to_working = 5'h0c,
      increment_skip_zero = 5'h0d,
      increment_skip_zero_to_working = 5'h0e,
      bit_high_skip = 5'h0f,
      byte_set = 5'h10,
      bit_set = 5'h11
   } op_t;

   // ==========================================================
   // Reset values and constants
   localparam logic [7:0] WORKING_RESET = 8'h00;
   localparam logic [7:0] ALL_ONES = 8'hff;
   localparam logic [7:0] ONE = 8'h01;
   localparam logic [3:0] FLAGS_RESET = 4'h0;
   localparam int FLAG_CARRY = 0;
   localparam int FLAG_HALF = 1;
   localparam int FLAG_ZERO = 2;
   localparam int FLAG_SIGNED = 3;
   localparam logic [1:0] SKIP_CYCLES = 2'h2;
endpackage : rss_pkg
